// [hw/pvsc_defs.vh]
`ifndef PVSC_DEFS_VH
`define PVSC_DEFS_VH

// Register byte offsets
`define PVSC_OFF_CONTROL 12'h170
`define PVSC_OFF_MATCH 12'h174
`define PVSC_OFF_MASK 12'h178
`define PVSC_OFF_COMPARE 12'h17c
`define PVSC_OFF_EXCHANGE 12'h180
`define PVSC_OFF_STATUS 12'h1a0

// Control register fields
`define PVSC_KIND_LSB 0
`define PVSC_KIND_MSB 1
`define PVSC_SPACE_BIT 2
`define PVSC_CONTROL_RESET 3'h0
`define PVSC_WORD_RESET 32'h0000_0000

// Special kind encodings
`define PVSC_KIND_OFF 2'h0
`define PVSC_KIND_RMW 2'h1
`define PVSC_KIND_AO 2'h2
`define PVSC_KIND_RSVD 2'h3

// Space select encodings
`define PVSC_SPACE_MEM 1'b0
`define PVSC_SPACE_IO 1'b1

// Match compares address bits 31:2
`define PVSC_MATCH_LSB 2

// Status register fields
`define PVSC_STAT_BUSY 0
`define PVSC_STAT_SWAPPED 1
`define PVSC_STAT_MISMATCH 2

// VMEbus cycle kinds presented to the VME master
`define PVSC_VCYC_READ 2'h0
`define PVSC_VCYC_WRITE 2'h1
`define PVSC_VCYC_AO 2'h2

`endif

// [hw/pvsc_merge.v]
`timescale 1ns/1ns
// Masked compare and masked merge of one data word
module pvsc_merge #(
    parameter WIDTH = 32
) (
    input wire [WIDTH-1:0] read_data,
    input wire [WIDTH-1:0] bit_mask,
    input wire [WIDTH-1:0] compare_value,
    input wire [WIDTH-1:0] exchange_value,
    output wire all_equal,
    output wire [WIDTH-1:0] merged
);
    wire [WIDTH-1:0] differs;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // Masked-off bits never count as a difference
            assign differs[i] = bit_mask[i] & (read_data[i] ^ compare_value[i]);
            // Masked-off bits keep what the slave returned
            assign merged[i] = bit_mask[i] ? exchange_value[i] : read_data[i];
        end
    endgenerate

    assign all_equal = ~|differs;
endmodule

// [hw/pvsc_gen.v]
`timescale 1ns/1ns
`include "pvsc_defs.vh"

module pvsc_gen #(
    parameter ADDR_WIDTH = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire pci_start,
    input wire [31:0] pci_addr,
    input wire pci_io,
    input wire pci_write,
    output reg pci_claim,
    output reg pci_no_ack64,
    output reg pci_done,
    output reg [31:0] pci_rdata,
    output reg vme_req,
    output reg [1:0] vme_cycle,
    output reg vme_lock,
    output reg [31:0] vme_addr,
    output reg [31:0] vme_wdata,
    input wire vme_ack,
    input wire [31:0] vme_rdata
);
    localparam ST_IDLE = 3'h0;
    localparam ST_AO = 3'h1;
    localparam ST_READ = 3'h2;
    localparam ST_CMP = 3'h3;
    localparam ST_WRITE = 3'h4;

    reg [2:0] control;
    reg [31:0] match_location;
    reg [31:0] bit_mask;
    reg [31:0] compare_value;
    reg [31:0] exchange_value;
    reg [2:0] state;
    reg [31:0] read_hold;
    reg last_swapped;
    reg last_mismatch;

    wire [1:0] special_kind;
    wire space_select;
    wire addr_equal;
    wire hit;
    wire rmw_go;
    wire ao_go;
    wire all_equal;
    wire [31:0] merged;
    wire setup;
    wire access_done;
    wire [11:0] offset;
    wire [ADDR_WIDTH+11:0] paddr_wide;
    wire [11:0] word_offset;
    wire refused;
    wire write_ok;
    wire busy;
    wire [31:0] status_word;
    reg mapped;
    reg [31:0] next_prdata;

    assign special_kind = control[`PVSC_KIND_MSB:`PVSC_KIND_LSB];
    assign space_select = control[`PVSC_SPACE_BIT];

    // Address-phase address against bits 31:2 only
    assign addr_equal = pci_addr[31:`PVSC_MATCH_LSB]
                        == match_location[31:`PVSC_MATCH_LSB];
    assign hit = addr_equal && (special_kind != `PVSC_KIND_OFF);
    // Reserved kind 11 starts no bus cycle, though a hit still withholds ACK64
    assign ao_go = hit && (special_kind == `PVSC_KIND_AO);
    // Space select is consulted only for read-modify-write
    assign rmw_go = hit && (special_kind == `PVSC_KIND_RMW) && !pci_write
                    && (pci_io == space_select);

    // Compare and merge act on the held read word, not on the live bus
    pvsc_merge #(
        .WIDTH(32)
    ) u_merge (
        .read_data(read_hold),
        .bit_mask(bit_mask),
        .compare_value(compare_value),
        .exchange_value(exchange_value),
        .all_equal(all_equal),
        .merged(merged)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            pci_claim <= 1'b0;
            pci_no_ack64 <= 1'b0;
            pci_done <= 1'b0;
            pci_rdata <= 32'h0000_0000;
            vme_req <= 1'b0;
            vme_cycle <= `PVSC_VCYC_READ;
            vme_lock <= 1'b0;
            vme_addr <= 32'h0000_0000;
            vme_wdata <= 32'h0000_0000;
            read_hold <= 32'h0000_0000;
            last_swapped <= 1'b0;
            last_mismatch <= 1'b0;
        end else begin
            pci_done <= 1'b0;
            // Starts seen outside idle are dropped; the PCI side has to retry them
            case (state)
                ST_IDLE: begin
                    // A match that is not claimed still withholds ACK64 for one cycle
                    pci_no_ack64 <= pci_start && hit;
                    if (pci_start && ao_go) begin
                        state <= ST_AO;
                        pci_claim <= 1'b1;
                        vme_req <= 1'b1;
                        vme_cycle <= `PVSC_VCYC_AO;
                        vme_addr <= {pci_addr[31:2], 2'b00};
                    end else if (pci_start && rmw_go) begin
                        state <= ST_READ;
                        pci_claim <= 1'b1;
                        vme_req <= 1'b1;
                        vme_cycle <= `PVSC_VCYC_READ;
                        vme_lock <= 1'b1;
                        vme_addr <= {pci_addr[31:2], 2'b00};
                    end
                end
                ST_AO: begin
                    if (vme_ack) begin
                        vme_req <= 1'b0;
                        state <= ST_IDLE;
                        pci_claim <= 1'b0;
                        pci_no_ack64 <= 1'b0;
                        pci_done <= 1'b1;
                        // Address-only carries no data, so PCI gets zero
                        pci_rdata <= 32'h0000_0000;
                    end
                end
                ST_READ: begin
                    if (vme_ack) begin
                        vme_req <= 1'b0;
                        // Held so compare and merge see one stable word
                        read_hold <= vme_rdata;
                        state <= ST_CMP;
                    end
                end
                ST_CMP: begin
                    // Live registers feed the compare; software must not change them now
                    if (all_equal) begin
                        // Lock stays up so the write-back is part of the same cycle
                        vme_req <= 1'b1;
                        vme_cycle <= `PVSC_VCYC_WRITE;
                        vme_wdata <= merged;
                        state <= ST_WRITE;
                    end else begin
                        vme_lock <= 1'b0;
                        state <= ST_IDLE;
                        pci_claim <= 1'b0;
                        pci_no_ack64 <= 1'b0;
                        pci_done <= 1'b1;
                        pci_rdata <= read_hold;
                        last_swapped <= 1'b0;
                        last_mismatch <= 1'b1;
                    end
                end
                ST_WRITE: begin
                    if (vme_ack) begin
                        vme_req <= 1'b0;
                        vme_lock <= 1'b0;
                        state <= ST_IDLE;
                        pci_claim <= 1'b0;
                        pci_no_ack64 <= 1'b0;
                        pci_done <= 1'b1;
                        // PCI sees the value found before the swap
                        pci_rdata <= read_hold;
                        last_swapped <= 1'b1;
                        last_mismatch <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    pci_claim <= 1'b0;
                    pci_no_ack64 <= 1'b0;
                    vme_req <= 1'b0;
                    vme_lock <= 1'b0;
                end
            endcase
        end
    end

    // APB slave: read data and error are captured in the setup cycle so that
    // both come from flops; the access phase always completes in one cycle.
    assign setup = psel && !penable;
    assign access_done = psel && penable && pready;
    // Zero-extend first so any bus width still yields twelve offset bits
    assign paddr_wide = {12'h000, paddr};
    assign offset = paddr_wide[11:0];
    // Registers are whole words; the low bits only matter for the error check
    assign word_offset = {offset[11:2], 2'b00};
    // Unmapped offsets, unaligned writes and writes to status are refused
    assign refused = !mapped || (pwrite && offset[1:0] != 2'b00)
                     || (pwrite && word_offset == `PVSC_OFF_STATUS);
    // A refused write leaves every register untouched
    assign write_ok = access_done && pwrite && !pslverr;
    // Busy is the live state; the sticky flags have no software clear
    assign busy = state != ST_IDLE;
    assign status_word = {29'h0, last_mismatch, last_swapped, busy};

    // An unaligned read returns the enclosing word
    always @* begin
        mapped = 1'b1;
        next_prdata = 32'h0000_0000;
        case (word_offset)
            `PVSC_OFF_CONTROL: begin
                next_prdata = {29'h0, control};
            end
            `PVSC_OFF_MATCH: begin
                next_prdata = match_location;
            end
            `PVSC_OFF_MASK: begin
                next_prdata = bit_mask;
            end
            `PVSC_OFF_COMPARE: begin
                next_prdata = compare_value;
            end
            `PVSC_OFF_EXCHANGE: begin
                next_prdata = exchange_value;
            end
            `PVSC_OFF_STATUS: begin
                next_prdata = status_word;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= refused;
            end else if (access_done) begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= `PVSC_CONTROL_RESET;
            match_location <= `PVSC_WORD_RESET;
            bit_mask <= `PVSC_WORD_RESET;
            compare_value <= `PVSC_WORD_RESET;
            exchange_value <= `PVSC_WORD_RESET;
        end else if (write_ok) begin
            case (word_offset)
                `PVSC_OFF_CONTROL: begin
                    control <= pwdata[2:0];
                end
                `PVSC_OFF_MATCH: begin
                    match_location <= pwdata;
                end
                `PVSC_OFF_MASK: begin
                    bit_mask <= pwdata;
                end
                `PVSC_OFF_COMPARE: begin
                    compare_value <= pwdata;
                end
                `PVSC_OFF_EXCHANGE: begin
                    exchange_value <= pwdata;
                end
                default: begin
                    control <= control;
                end
            endcase
        end
    end
endmodule

// [tb/pvsc_chk.sv]
`timescale 1ns/1ns
`include "pvsc_defs.vh"
module pvsc_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pci_claim,
    input wire pci_no_ack64,
    input wire pci_done,
    input wire vme_req,
    input wire [1:0] vme_cycle,
    input wire vme_lock,
    input wire [31:0] vme_addr,
    input wire vme_ack
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_claim_withholds: assert property (pci_claim |-> pci_no_ack64)
        else $error("claimed access allows 64-bit ack");
    a_claim_starts_req: assert property ($rose(pci_claim) |-> vme_req
        && vme_cycle != `PVSC_VCYC_WRITE)
        else $error("claim without a first bus request");
    a_req_holds: assert property (vme_req && !vme_ack |=> vme_req
        && $stable(vme_cycle) && $stable(vme_addr))
        else $error("request changed before ack");
    a_req_drops: assert property (vme_req && vme_ack |=> !vme_req)
        else $error("request held after ack");
    a_lock_read_first: assert property ($rose(vme_lock) |-> vme_req
        && vme_cycle == `PVSC_VCYC_READ)
        else $error("lock not opened by a read");
    a_write_locked: assert property (vme_req && vme_cycle == `PVSC_VCYC_WRITE
        |-> vme_lock)
        else $error("write-back outside the lock");
    a_ao_done: assert property (vme_req && vme_ack && vme_cycle == `PVSC_VCYC_AO
        |=> pci_done && !pci_claim && !vme_lock)
        else $error("address-only cycle not finished");
    a_addr_word: assert property (vme_req |-> vme_addr[1:0] == 2'b00)
        else $error("bus address not word aligned");
    cover property (vme_req && vme_ack && vme_cycle == `PVSC_VCYC_WRITE);
    cover property (vme_req && vme_ack && vme_cycle == `PVSC_VCYC_AO);
    cover property ($fell(vme_lock) && pci_done);
endmodule

bind pvsc_gen pvsc_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pci_claim,
    .pci_no_ack64, .pci_done, .vme_req, .vme_cycle, .vme_lock, .vme_addr, .vme_ack);

// [tb/pvsc_vme_model.sv]
`timescale 1ns/1ns
`include "pvsc_defs.vh"
// One-word bus slave; the address is ignored, so one location stands for all
module pvsc_vme_model (
    input wire pclk,
    input wire presetn,
    input wire vme_req,
    input wire [1:0] vme_cycle,
    input wire [31:0] vme_wdata,
    input wire [1:0] dly,
    output logic vme_ack,
    output logic [31:0] vme_rdata
);
    logic [31:0] mem;
    logic [1:0] cnt;
    // Data toggles except in the ack cycle and while a request counts down its delay, so a stale read cannot pass
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vme_ack <= 1'b0;
            cnt <= 2'h0;
            vme_rdata <= 32'h0;
        end else if (vme_ack) begin
            vme_ack <= 1'b0;
            vme_rdata <= ~vme_rdata;
        end else if (vme_req && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else if (vme_req) begin
            vme_ack <= 1'b1;
            cnt <= dly;
            vme_rdata <= mem;
            if (vme_cycle == `PVSC_VCYC_WRITE) begin
                mem <= vme_wdata;
            end
        end else begin
            vme_rdata <= ~vme_rdata;
        end
    end
endmodule

// [tb/pvsc_gen_bench.sv]
`timescale 1ns/1ns
`include "pvsc_defs.vh"
module pvsc_gen_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pci_start = 1'b0, pci_io = 1'b0, pci_write = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, pci_addr = 32'h0;
    logic [1:0] dly = 2'h0;
    wire [31:0] prdata, pci_rdata, vme_addr, vme_wdata, vme_rdata;
    wire pready, pslverr, pci_claim, pci_no_ack64, pci_done, vme_req, vme_lock, vme_ack;
    wire [1:0] vme_cycle;
    int errors = 0, n_compared = 0, cyc = 0;
    integer seed = 32'h86f0a58d;
    always #4 pclk = ~pclk;
    pvsc_gen uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pci_start, .pci_addr, .pci_io, .pci_write, .pci_claim,
        .pci_no_ack64, .pci_done, .pci_rdata, .vme_req, .vme_cycle, .vme_lock, .vme_addr,
        .vme_wdata, .vme_ack, .vme_rdata);
    pvsc_vme_model m (.pclk, .presetn, .vme_req, .vme_cycle, .vme_wdata, .dly, .vme_ack,
        .vme_rdata);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until the rising edge at which ready is seen; data taken there
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pci(input logic [31:0] a, input logic io, input logic w,
        output logic dn, output logic na, output logic [31:0] rd);
        int n;
        @(posedge pclk);
        pci_start <= 1'b1;
        pci_addr <= a;
        pci_io <= io;
        pci_write <= w;
        @(posedge pclk);
        pci_start <= 1'b0;
        dn = 1'b0;
        na = 1'b0;
        rd = 32'h0;
        // Refused accesses never finish, so the wait is bounded
        for (n = 0; n < 24 && !dn; n++) begin
            @(negedge pclk);
            na = na | pci_no_ack64;
            dn = pci_done;
            rd = pci_rdata;
        end
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            errors++;
            finish_test;
        end
    end
    initial begin
        logic [31:0] q, a, d, mk, cv, xv, r;
        logic e, dn, na, w, io, sp, hit, cl, sw;
        logic [1:0] k;
        int i;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, `PVSC_OFF_CONTROL + 12'(4 * i), 32'h0, q, e);
            chk(q, 32'h0);
            d = $random(seed);
            apb(1'b1, `PVSC_OFF_CONTROL + 12'(4 * i), d, q, e);
            apb(1'b0, `PVSC_OFF_CONTROL + 12'(4 * i), 32'h0, q, e);
            chk(q, i == 0 ? d & 32'h7 : d);
        end
        apb(1'b0, 12'h1f0, 32'h0, q, e);
        chk(e, 1'b1);
        chk(q, 32'h0);
        apb(1'b1, `PVSC_OFF_STATUS, 32'hffff_ffff, q, e);
        chk(e, 1'b1);
        apb(1'b0, `PVSC_OFF_STATUS, 32'h0, q, e);
        chk(q, 32'h0);
        $display("test registers done");
        for (i = 0; i < 32; i++) begin
            k = 2'(i);
            hit = (i % 3) != 0;
            {w, io, sp} = 3'($random(seed));
            // Corner cases first: reads that qualify for read-modify-write
            if (i < 16) begin
                w = 1'b0;
                io = sp;
            end
            a = $random(seed);
            mk = $random(seed);
            cv = $random(seed);
            xv = $random(seed);
            r = i[2] ? $random(seed) : (cv & mk) | ($random(seed) & ~mk);
            sw = ((r ^ cv) & mk) == 32'h0;
            dly <= 2'($random(seed));
            m.mem = r;
            apb(1'b1, `PVSC_OFF_MATCH, a, q, e);
            apb(1'b1, `PVSC_OFF_MASK, mk, q, e);
            apb(1'b1, `PVSC_OFF_COMPARE, cv, q, e);
            apb(1'b1, `PVSC_OFF_EXCHANGE, xv, q, e);
            apb(1'b1, `PVSC_OFF_CONTROL, {29'h0, sp, k}, q, e);
            pci(hit ? a ^ (32'h3 & $random(seed)) : a ^ 32'h10, io, w, dn, na, q);
            cl = hit && (k == `PVSC_KIND_AO || (k == `PVSC_KIND_RMW && !w && io == sp));
            chk(dn, cl);
            chk(na, hit && k != `PVSC_KIND_OFF);
            if (cl) begin
                chk(q, k == `PVSC_KIND_AO ? 32'h0 : r);
            end
            if (cl && k == `PVSC_KIND_RMW) begin
                apb(1'b0, `PVSC_OFF_STATUS, 32'h0, q, e);
                chk(q, {29'h0, !sw, sw, 1'b0});
            end
            chk(m.mem, cl && k == `PVSC_KIND_RMW && ((r ^ cv) & mk) == 32'h0 ?
                (r & ~mk) | (xv & mk) : r);
        end
        $display("test special cycles done");
        finish_test;
    end
endmodule
